// ---- dv/dpt_timer_props.sv ----
// port checker for the dual programmable timer, bound to its top
`include "dpt_consts.vh"
// =============================================
// port watcher
module dpt_timer_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        low_speed_oscillator,
    input wire logic        high_speed_oscillator,
    input wire logic        ref_2048hz,
    input wire logic        event_input_pin,
    input wire logic        timer_output_pin,
    input wire logic        serial_clock,
    input wire logic        irq_request_t0,
    input wire logic        irq_request_t1
);
    timeunit 1ns;
    timeprecision 1ps;
    // write access phase, the only way software can clear or mask
    wire wr_acc = psel && penable && pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // zero wait states on every transfer
    ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
        else $error("pready missing after setup");
    ready_one_cycle_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready not a single access pulse");
    slverr_no_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    strobe_reads_zero_a: assert property (pready && !pwrite && paddr == `DPT_OFS_STROBE
        |-> prdata == 32'h0)
        else $error("reload strobe register read not zero");
    // source edges are at least three cycles apart, so are underflows
    serial_spacing_a: assert property ($changed(serial_clock) |=> $stable(serial_clock) [*2])
        else $error("serial clock toggled too fast");
    irq_fall_cause_a: assert property ($fell(irq_request_t0)
        |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("irq t0 dropped without a write");
    irq_rise_cause_a: assert property ($rose(irq_request_t1) |-> $changed(serial_clock)
        || $past(serial_clock) != $past(serial_clock, 2) || $past(wr_acc) || $past(wr_acc, 2))
        else $error("irq t1 rose without underflow or write");
    pin_spacing_a: assert property ($changed(timer_output_pin) && !$past(wr_acc)
        |=> $stable(timer_output_pin))
        else $error("pulse output toggled on consecutive cycles");
endmodule // dpt_timer_props

bind dpt_timer dpt_timer_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_oscillator(low_speed_oscillator), .high_speed_oscillator(high_speed_oscillator),
    .ref_2048hz(ref_2048hz), .event_input_pin(event_input_pin),
    .timer_output_pin(timer_output_pin), .serial_clock(serial_clock),
    .irq_request_t0(irq_request_t0), .irq_request_t1(irq_request_t1));

// ---- dv/dpt_timer_tb_top.sv ----
// self-checking testbench for the dual programmable timer
`include "dpt_consts.vh"
module dpt_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, lso, hso, ref_clk, evp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, tpin, sclk, irq0, irq1;
    int          n_errors, tests_run, ref_cnt;
    // =============================================
    // design
    dpt_timer dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_speed_oscillator(lso), .high_speed_oscillator(hso), .ref_2048hz(ref_clk),
        .event_input_pin(evp), .timer_output_pin(tpin), .serial_clock(sclk),
        .irq_request_t0(irq0), .irq_request_t1(irq1));
    // clock, and a slow reference standing in for the 2048 Hz signal
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // regular reference, period 20 cycles: a random one could fall twice inside a glitch
    always @(posedge pclk)
    begin
        ref_cnt <= (ref_cnt == 9) ? 0 : ref_cnt + 1;
        if (ref_cnt == 9)
            ref_clk <= ~ref_clk;
    end
    // =============================================
    // helpers
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; waits for pready with a bound, never assumes latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r);
    endtask
    // source edges six cycles apart; each source gets its own count
    task automatic src(input int nl, input int nh);
        for (int i = 0; i < (nl > nh ? nl : nh); i++)
        begin
            @(posedge pclk); lso <= (i < nl); hso <= (i < nh);
            repeat (3) @(posedge pclk);
            lso <= 1'b0; hso <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
    endtask
    task automatic ev_tog(input int hold);
        @(posedge pclk);
        evp <= ~evp;
        repeat (hold) @(posedge pclk);
    endtask
    // reference down-counter: reload on a tick at zero
    function automatic logic [15:0] mdl(input logic [15:0] rl, input int t, output int uf);
        logic [15:0] c;
        c = rl;
        uf = 0;
        repeat (t) if (c == 16'h0) begin c = rl; uf++; end else c--;
        return c;
    endfunction
    // =============================================
    // tests
    initial
    begin
        int          div, k, uf;
        logic [15:0] c, rl, c0;
        logic [31:0] cw, r;
        logic        e, sc0, tp0, en;
        {psel, penable, pwrite, lso, hso, ref_clk, evp} = 7'h0;
        paddr = 12'h000; pwdata = 32'h0; presetn = 1'b0; n_errors = 0; tests_run = 0;
        ref_cnt = 0;
        c0 = 16'h0;
        void'($urandom(32'h040C));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl", `DPT_OFS_CTRL, 32'h0);
        rdc("flags", `DPT_OFS_FLAGS, 32'h0);
        rdc("strobe", `DPT_OFS_STROBE, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0, r, e);
        chk("unmapped err", 32'h1, e);
        // each channel, each ratio, each source; the other source gets five more edges
        for (int ch = 0; ch < 2; ch++) for (int ps = 0; ps < 4; ps++) for (int s = 0; s < 2; s++)
        begin
            div = (ps == 0) ? 1 : (ps == 1) ? 4 : (ps == 2) ? 32 : 256;
            rl = (s == 1 && ps == 0) ? 16'h0 : 16'($urandom_range(255, 1));
            k = (ps == 0) ? $urandom_range(rl + 3, 1) : $urandom_range(3, 1);
            en = 1'($urandom_range(1, 0));
            cw = 32'h80 | (ch << 6) | (s << (8 + ch)) | (ps << (10 + 2 * ch));
            wr(`DPT_OFS_CTRL, cw);
            wr(`DPT_OFS_RELOAD, {16'h0, rl[7:0] << 0} << (8 * ch));
            wr(`DPT_OFS_FLAGS, 32'h3);
            wr(`DPT_OFS_IRQEN, {31'h0, en} << ch);
            wr(`DPT_OFS_STROBE, 32'h1 << ch);
            sc0 = sclk;
            tp0 = tpin;
            wr(`DPT_OFS_CTRL, cw | (32'h1 << ch));
            src(s ? div * k + 5 : div * k, s ? div * k : div * k + 5);
            wr(`DPT_OFS_CTRL, cw);
            c = mdl(rl, k, uf);
            // timer 0 stays stopped through the timer 1 passes
            if (ch == 0) c0 = c;
            src(3, 3);
            if (ch == 1) rdc("cnt lo", `DPT_OFS_CNT_LO, {16'h0, c0});
            rdc(ch ? "cnt t1" : "cnt t0", ch ? `DPT_OFS_CNT_HI : `DPT_OFS_CNT_LO, c);
            chk("irq other", 32'h0, ch ? irq0 : irq1);
            rdc("flags", `DPT_OFS_FLAGS, {30'h0, uf > 0, 1'b0} >> (1 - ch));
            chk("irq", en && uf > 0, ch ? irq1 : irq0);
            chk("serial clock", sc0 ^ (ch == 1 && uf[0]), sclk);
            chk("pulse pin", tp0 ^ uf[0], tpin);
            wr(`DPT_OFS_FLAGS, 32'h0);
            rdc("flags kept", `DPT_OFS_FLAGS, {30'h0, uf > 0, 1'b0} >> (1 - ch));
            wr(`DPT_OFS_FLAGS, 32'h1 << ch);
            rdc("flags clear", `DPT_OFS_FLAGS, 32'h0);
        end
        // event counting, both polarities, with and without the rejector
        for (int f = 0; f < 2; f++) for (int pol = 0; pol < 2; pol++)
        begin
            rl = 16'($urandom_range(200, 5));
            k = $urandom_range(4, 1);
            wr(`DPT_OFS_RELOAD, {16'h0, rl});
            wr(`DPT_OFS_STROBE, 32'h1);
            wr(`DPT_OFS_CTRL, 32'hC09 | (pol << 4) | (f << 5));
            repeat (2 * k)
            begin
                if (f) begin ev_tog(3); ev_tog(90); end
                ev_tog(f ? 120 : 6);
            end
            wr(`DPT_OFS_CTRL, 32'h0);
            rdc("event count", `DPT_OFS_CNT_LO, mdl(rl, k, uf));
        end
        // chained 16-bit count crossing a low-byte borrow, only run t0 set
        rl = {8'($urandom_range(3, 1)), 8'($urandom_range(255, 0))};
        k = rl[7:0] + 3;
        wr(`DPT_OFS_RELOAD, {16'h0, rl});
        wr(`DPT_OFS_STROBE, 32'h3);
        wr(`DPT_OFS_CTRL, 32'h5);
        src(k, 0);
        wr(`DPT_OFS_CTRL, 32'h4);
        c = mdl(rl, k, uf);
        rdc("chain lo", `DPT_OFS_CNT_LO, c[7:0]);
        rdc("chain hi", `DPT_OFS_CNT_HI, c[15:8]);
        stop_test();
    end
    // watchdog at 80k cycles, about four times the expected run of some 20k cycles
    initial
    begin
        #800000;
        n_errors++;
        stop_test();
    end
endmodule // dpt_timer_tb_top

// ---- hdl/dpt_consts.vh ----
// constants for the dual 8-bit programmable timer
`ifndef DPT_CONSTS_VH
`define DPT_CONSTS_VH

// =============================================
// register byte offsets
`define DPT_OFS_CTRL    12'h000
`define DPT_OFS_RELOAD  12'h004
`define DPT_OFS_STROBE  12'h008
`define DPT_OFS_CNT_LO  12'h00C
`define DPT_OFS_CNT_HI  12'h010
`define DPT_OFS_FLAGS   12'h014
`define DPT_OFS_IRQEN   12'h018

// =============================================
// control register fields
`define DPT_CB_RUN0     0
`define DPT_CB_RUN1     1
`define DPT_CB_CHAIN    2
`define DPT_CB_EVCOUNT  3
`define DPT_CB_EDGEPOL  4
`define DPT_CB_FILTER   5
`define DPT_CB_OUTPUT_CHANNEL_SELECT    6
`define DPT_CB_POUTEN   7
`define DPT_CB_SOURCE_CLOCK_SELECT_T0   8
`define DPT_CB_SOURCE_CLOCK_SELECT_T1   9
`define DPT_CB_PS0_LO   10
`define DPT_CB_PS0_HI   11
`define DPT_CB_PS1_LO   12
`define DPT_CB_PS1_HI   13
`define DPT_CTRL_MSB    13

// =============================================
// reset values and widths
`define DPT_CTRL_RST    14'h0000
`define DPT_BYTE_RST    8'h00
`define DPT_BYTE_LAST   8'hFF
`define DPT_WORD_ZERO   32'h00000000
`define DPT_ZERO8       8'h00

// =============================================
// prescaler ratio codes and terminal counts
`define DPT_PS_DIV1     2'h0
`define DPT_PS_DIV4     2'h1
`define DPT_PS_DIV32    2'h2
`define DPT_PS_DIV256   2'h3
`define DPT_TC_DIV1     8'h00
`define DPT_TC_DIV4     8'h03
`define DPT_TC_DIV32    8'h1F
`define DPT_TC_DIV256   8'hFF

// =============================================
// noise filter: accept at this many falling edges
`define DPT_FILT_EDGES  2'h2
`define DPT_FILT_ONE    2'h1
`define DPT_FILT_ZERO   2'h0

`endif

// ---- hdl/dpt_prescaler.v ----
// ratio prescaler for one channel; source clock select is done in the timer
`include "dpt_consts.vh"

module dpt_prescaler (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       src_tick,
    input  wire       run,
    input  wire [1:0] ratio,
    output reg        count_tick
);

    reg  [7:0] div_q;
    reg  [7:0] div_d;
    reg  [7:0] term;

    // =============================================
    // terminal count from ratio code
    always @*
    begin
        case (ratio)
            `DPT_PS_DIV1:   term = `DPT_TC_DIV1;
            `DPT_PS_DIV4:   term = `DPT_TC_DIV4;
            `DPT_PS_DIV32:  term = `DPT_TC_DIV32;
            default:        term = `DPT_TC_DIV256;
        endcase
    end

    // =============================================
    // divider; held cleared while stopped so restart is clean
    always @*
    begin
        div_d = div_q;
        if (!run)
            div_d = `DPT_ZERO8;
        else if (src_tick)
            div_d = (div_q >= term) ? `DPT_ZERO8 : div_q + 8'h01;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q      <= `DPT_ZERO8;
            count_tick <= 1'b0;
        end
        else
        begin
            div_q      <= div_d;
            count_tick <= run & src_tick & (div_q >= term);
        end
    end

endmodule // dpt_prescaler

// ---- hdl/dpt_timer.v ----
// dual 8-bit reloading down-counter with APB register access
//
// Local design decisions: the register offsets and register access over APB.
`include "dpt_consts.vh"

// What this block does
// - two 8-bit counters, separate or chained
// - reload strobe copies reload value in
// - run bit starts, stop holds count
// - low readback read latches high part
// - underflow reloads and keeps counting
// - underflow drives flag, pulse, serial clock
// - serial clock from timer 1 underflows
// - source select: timer or event, reset timer
// - timer 1 counts prescaled clock only
// - event mode ignores timer 0 prescaler
// - polarity picks falling or rising edge
// - filter enable inserts noise rejector
// - accept change at second 2048 Hz fall
// - clock select low or high oscillator
// - prescaler runs only with run bit
// - flag always set, request needs enable
// - pulse toggles on chosen timer underflow
// - serial clock toggles on timer 1 underflow
// - chained: timer 0 low, timer 1 high
// - chained: timer 0 run controls both
module dpt_timer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        low_speed_oscillator,
    input  wire        high_speed_oscillator,
    input  wire        ref_2048hz,
    input  wire        event_input_pin,
    output reg         timer_output_pin,
    output reg         serial_clock,
    output reg         irq_request_t0,
    output reg         irq_request_t1
);

    // =============================================
    // registers and state
    reg  [`DPT_CTRL_MSB:0] ctrl_q;
    reg  [7:0]  reload_value_t0_q, reload_value_t1_q;
    reg  [7:0]  cnt0_q, cnt1_q, cnt0_d, cnt1_d, hi_hold_q;
    reg         underflow_flag_t0_q, underflow_flag_t1_q, irq_en_t0_q, irq_en_t1_q;
    reg         pulse_output_q, uf0, uf1;
    reg         lso_q, hso_q, ref_q;
    reg         ev_meta_q, ev_sync_q, ev_level_q, ev_prev_q;
    reg  [1:0]  filt_cnt_q;
    reg         filt_level_q;

    wire        run_control_t0         = ctrl_q[`DPT_CB_RUN0];
    wire        run_control_t1         = ctrl_q[`DPT_CB_RUN1];
    wire        chain_mode             = ctrl_q[`DPT_CB_CHAIN];
    wire        count_source_select    = ctrl_q[`DPT_CB_EVCOUNT];
    wire        event_edge_polarity    = ctrl_q[`DPT_CB_EDGEPOL];
    wire        noise_filter_enable    = ctrl_q[`DPT_CB_FILTER];
    wire        output_channel_select  = ctrl_q[`DPT_CB_OUTPUT_CHANNEL_SELECT];
    wire        pulse_output_enable    = ctrl_q[`DPT_CB_POUTEN];
    wire        source_clock_select_t0 = ctrl_q[`DPT_CB_SOURCE_CLOCK_SELECT_T0];
    wire        source_clock_select_t1 = ctrl_q[`DPT_CB_SOURCE_CLOCK_SELECT_T1];
    wire [1:0]  prescale_ratio_t0      = {ctrl_q[`DPT_CB_PS0_HI], ctrl_q[`DPT_CB_PS0_LO]};
    wire [1:0]  prescale_ratio_t1      = {ctrl_q[`DPT_CB_PS1_HI], ctrl_q[`DPT_CB_PS1_LO]};

    // =============================================
    // bus decode
    wire        setup_ph  = psel & ~penable;
    wire        access_ok = psel & penable & pready;
    wire        wr_ok     = access_ok & pwrite & ~pslverr;
    wire        rd_ok     = access_ok & ~pwrite & ~pslverr;

    // address hit helper, used by the write decodes and the low count read
    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    wire        wr_ctrl   = wr_ok & hit(paddr, `DPT_OFS_CTRL);
    wire        wr_reload = wr_ok & hit(paddr, `DPT_OFS_RELOAD);
    wire        wr_strobe = wr_ok & hit(paddr, `DPT_OFS_STROBE);
    wire        wr_flags  = wr_ok & hit(paddr, `DPT_OFS_FLAGS);
    wire        wr_irqen  = wr_ok & hit(paddr, `DPT_OFS_IRQEN);
    wire        rd_cnt_lo = rd_ok & hit(paddr, `DPT_OFS_CNT_LO);
    wire        reload_strobe_t0 = wr_strobe & pwdata[0];
    wire        reload_strobe_t1 = wr_strobe & pwdata[1];

    // =============================================
    // oscillator and reference edge sampling
    wire        lso_rise = low_speed_oscillator & ~lso_q;
    wire        hso_rise = high_speed_oscillator & ~hso_q;
    wire        ref_fall = ~ref_2048hz & ref_q;
    wire        src0 = source_clock_select_t0 ? hso_rise : lso_rise;
    wire        src1 = source_clock_select_t1 ? hso_rise : lso_rise;
    wire        pre0_tick, pre1_tick;

    // =============================================
    // prescalers; timer 1 runs from its own run bit even when chained
    dpt_prescaler u_pre0 (
        .pclk       (pclk),
        .presetn    (presetn),
        .src_tick   (src0),
        .run        (run_control_t0),
        .ratio      (prescale_ratio_t0),
        .count_tick (pre0_tick)
    );

    dpt_prescaler u_pre1 (
        .pclk       (pclk),
        .presetn    (presetn),
        .src_tick   (src1),
        .run        (run_control_t1),
        .ratio      (prescale_ratio_t1),
        .count_tick (pre1_tick)
    );

    // =============================================
    // event input path: sync, optional filter, edge detect
    // two-stage synchroniser
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_meta_q <= 1'b0;
            ev_sync_q <= 1'b0;
            lso_q     <= 1'b0;
            hso_q     <= 1'b0;
            ref_q     <= 1'b0;
        end
        else
        begin
            ev_meta_q <= event_input_pin;
            ev_sync_q <= ev_meta_q;
            lso_q     <= low_speed_oscillator;
            hso_q     <= high_speed_oscillator;
            ref_q     <= ref_2048hz;
        end
    end

    // accept change at second reference fall
    // a change that reverts before then restarts the wait
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filt_cnt_q   <= `DPT_FILT_ZERO;
            filt_level_q <= 1'b0;
        end
        else if (ev_sync_q == filt_level_q)
            filt_cnt_q <= `DPT_FILT_ZERO;
        else if (ref_fall)
        begin
            if (filt_cnt_q == `DPT_FILT_ONE)
            begin
                filt_level_q <= ev_sync_q;
                filt_cnt_q   <= `DPT_FILT_ZERO;
            end
            else
                filt_cnt_q <= filt_cnt_q + `DPT_FILT_ONE;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_level_q <= 1'b0;
            ev_prev_q  <= 1'b0;
        end
        else
        begin
            ev_level_q <= noise_filter_enable ? filt_level_q : ev_sync_q;
            ev_prev_q  <= ev_level_q;
        end
    end

    wire        ev_edge = event_edge_polarity ? (ev_level_q & ~ev_prev_q)
                                              : (~ev_level_q & ev_prev_q);

    // =============================================
    // count enables
    // source select chooses timer or event
    wire        tick0 = run_control_t0 & (count_source_select ? ev_edge : pre0_tick);
    // chained halves follow timer 0 run
    wire        tick1 = chain_mode ? 1'b0 : pre1_tick;

    // =============================================
    // down counters with reload on underflow
    always @*
    begin
        cnt0_d = cnt0_q;
        cnt1_d = cnt1_q;
        uf0    = 1'b0;
        uf1    = 1'b0;
        if (tick0)
        begin
            if (cnt0_q == `DPT_ZERO8)
            begin
                uf0 = 1'b1;
                if (chain_mode)
                begin
                    if (cnt1_q == `DPT_ZERO8)
                    begin
                        uf1    = 1'b1;
                        cnt0_d = reload_value_t0_q;
                        cnt1_d = reload_value_t1_q;
                    end
                    else
                    begin
                        cnt0_d = `DPT_BYTE_LAST;
                        cnt1_d = cnt1_q - 8'h01;
                    end
                end
                else
                    cnt0_d = reload_value_t0_q;
            end
            else
                cnt0_d = cnt0_q - 8'h01;
        end
        if (tick1)
        begin
            if (cnt1_q == `DPT_ZERO8)
            begin
                uf1    = 1'b1;
                cnt1_d = reload_value_t1_q;
            end
            else
                cnt1_d = cnt1_q - 8'h01;
        end
        if (reload_strobe_t0)
            cnt0_d = reload_value_t0_q;
        if (reload_strobe_t1)
            cnt1_d = reload_value_t1_q;
    end

    // =============================================
    // software registers, flags, counters and readback hold
    // counters hold when stopped
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt0_q              <= `DPT_BYTE_RST;
            cnt1_q              <= `DPT_BYTE_RST;
            hi_hold_q           <= `DPT_BYTE_RST;
            ctrl_q              <= `DPT_CTRL_RST;
            reload_value_t0_q   <= `DPT_BYTE_RST;
            reload_value_t1_q   <= `DPT_BYTE_RST;
            irq_en_t0_q         <= 1'b0;
            irq_en_t1_q         <= 1'b0;
            underflow_flag_t0_q <= 1'b0;
            underflow_flag_t1_q <= 1'b0;
        end
        else
        begin
            cnt0_q              <= cnt0_d;
            cnt1_q              <= cnt1_d;
            if (rd_cnt_lo)
                hi_hold_q <= cnt1_q;
            if (wr_ctrl)
                ctrl_q <= pwdata[`DPT_CTRL_MSB:0];
            if (wr_reload)
            begin
                reload_value_t0_q <= pwdata[7:0];
                reload_value_t1_q <= pwdata[15:8];
            end
            if (wr_irqen)
            begin
                irq_en_t0_q <= pwdata[0];
                irq_en_t1_q <= pwdata[1];
            end
            underflow_flag_t0_q <= uf0 | (underflow_flag_t0_q & ~(wr_flags & pwdata[0]));
            underflow_flag_t1_q <= uf1 | (underflow_flag_t1_q & ~(wr_flags & pwdata[1]));
        end
    end

    // =============================================
    // pulse output and serial clock
    // toggle on chosen underflow
    wire        pulse_output_d = pulse_output_q ^ (output_channel_select ? uf1 : uf0);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_output_q   <= 1'b0;
            timer_output_pin <= 1'b1;
            serial_clock     <= 1'b0;
            irq_request_t0   <= 1'b0;
            irq_request_t1   <= 1'b0;
        end
        else
        begin
            pulse_output_q   <= pulse_output_d;
            // disabled pin idles high
            timer_output_pin <= pulse_output_enable ? pulse_output_d : 1'b1;
            // serial rate set by timer 1
            if (uf1)
                serial_clock <= ~serial_clock;
            irq_request_t0   <= irq_en_t0_q & (uf0 | (underflow_flag_t0_q
                                & ~(wr_flags & pwdata[0])));
            irq_request_t1   <= irq_en_t1_q & (uf1 | (underflow_flag_t1_q
                                & ~(wr_flags & pwdata[1])));
        end
    end

    // =============================================
    // APB answer: one access cycle, data captured in setup
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `DPT_WORD_ZERO;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= 1'b0;
            prdata  <= `DPT_WORD_ZERO;
            if (setup_ph)
            begin
                case (paddr)
                    `DPT_OFS_CTRL:   prdata <= {18'h00000, ctrl_q};
                    `DPT_OFS_RELOAD: prdata <= {16'h0000, reload_value_t1_q, reload_value_t0_q};
                    `DPT_OFS_STROBE: prdata <= `DPT_WORD_ZERO;
                    `DPT_OFS_CNT_LO: prdata <= {24'h000000, cnt0_q};
                    `DPT_OFS_CNT_HI: prdata <= {24'h000000, hi_hold_q};
                    `DPT_OFS_FLAGS:  prdata <= {30'h0, underflow_flag_t1_q, underflow_flag_t0_q};
                    `DPT_OFS_IRQEN:  prdata <= {30'h0, irq_en_t1_q, irq_en_t0_q};
                    default:         pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule // dpt_timer
